// file: core/ssmb_pkg.sv
// Shared constants of the status message code engine
`default_nettype none
package ssmb_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL = 8'h37;
	localparam logic [7:0] IDX_TXMSG = 8'hC1;
	localparam logic [7:0] IDX_RXMSG = 8'hC0;
	localparam logic [7:0] IDX_STAT = 8'h24;
	localparam logic [7:0] IDX_IEN = 8'h25;
	localparam logic [7:0] IDX_ICLR = 8'h26;
	localparam int ADDR_W = 12;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// Control register fields
	localparam int CTRL_W = 5;
	localparam int CTRL_SEND = 0;
	localparam int CTRL_FLT_LO = 1;
	localparam int CTRL_FLT_HI = 2;
	localparam int CTRL_RXRST = 3;
	localparam int CTRL_RXEN = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
	// Event status fields
	localparam int STAT_W = 1;
	localparam int STAT_CHG = 0;
	// Message and code word layout
	localparam int MSG_W = 6;
	localparam logic [5:0] RX_PRESET = 6'h3F;
	localparam logic [5:0] TX_RESET = 6'h00;
	localparam int WORD_W = 16;
	localparam logic [7:0] ABORT_BYTE = 8'hFF;
	localparam logic [3:0] LAST_BIT = 4'hF;
	// Consecutive matching codes needed per filter setting
	localparam logic [2:0] FLT_NONE = 3'h1;
	localparam logic [2:0] FLT_THREE = 3'h3;
	localparam logic [2:0] FLT_FIVE = 3'h5;
	localparam logic [2:0] FLT_SEVEN = 3'h7;
	// Quality level codes
	localparam logic [5:0] QL_STRATUM1 = 6'h02;
	localparam logic [5:0] QL_UNKNOWN = 6'h04;
	localparam logic [5:0] QL_STRATUM2 = 6'h06;
	localparam logic [5:0] QL_STRATUM3 = 6'h08;
	localparam logic [5:0] QL_USER = 6'h20;
	localparam logic [5:0] QL_SONET_MIN = 6'h11;
	localparam logic [5:0] QL_STRATUM4 = 6'h14;
	localparam logic [5:0] QL_DO_NOT_USE = 6'h18;
endpackage
`default_nettype wire

// file: core/ssmb_rx_filter.sv
// Receive code persistence filter
`timescale 1ns/1ps
`default_nettype none
module ssmb_rx_filter #(
	parameter int MSG_W = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic clr,
	// Framed codes from the detector
	input wire logic code_stb,
	input wire logic [MSG_W-1:0] code,
	input wire logic err_stb,
	input wire logic [1:0] sel,
	// Accepted code
	output logic acc_stb,
	output logic [MSG_W-1:0] acc_code
);
	logic [MSG_W-1:0] cand_r;
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic [2:0] need;

	always_comb begin
		case (sel)
			2'h0: need = ssmb_pkg::FLT_NONE;
			2'h1: need = ssmb_pkg::FLT_THREE;
			2'h2: need = ssmb_pkg::FLT_FIVE;
			default: need = ssmb_pkg::FLT_SEVEN;
		endcase
	end

	// Count saturates so acceptance fires only once per run
	always_comb begin
		cnt_nxt = cnt_r;
		if (err_stb) begin
			cnt_nxt = 3'h0;
		end else if (code_stb) begin
			if (cnt_r != 3'h0 && code == cand_r) begin
				cnt_nxt = (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
			end else begin
				cnt_nxt = 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst || clr) begin
			cnt_r <= 3'h0;
			cand_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			if (code_stb && !err_stb) begin
				cand_r <= code;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst || clr) begin
			acc_stb <= 1'b0;
			acc_code <= '0;
		end else begin
			acc_stb <= code_stb && !err_stb && cnt_nxt == need &&
				cnt_r != need;
			acc_code <= code;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst || clr);

	a_filter_need: assert property (acc_stb |-> $past(cnt_nxt) == $past(need))
		else $error("code accepted before filter count");
	a_filter_run: assert property (code_stb && !err_stb && cnt_r == 3'h0 &&
		need != 3'h1 |=> !acc_stb)
		else $error("first code accepted under active filter");
endmodule
`default_nettype wire

// file: core/ssmb_engine.sv
// Status message code engine: AHB-Lite registers, code send and receive
// What this block does
// - Each code word goes out as zero, six message bits, zero, eight ones.
// - The guard zeros and the all-ones byte are made here, not by software.
// - Setting the send bit starts code words at the next data link slot.
// - Code words repeat while the send bit is set and stop at the end of the current word once it clears.
// - Code detection runs only while the receive enable bit is set.
// - With detection on, the rx register holds the accepted message.
// - The rx message bits read all ones until a code is accepted.
// - A change of accepted code sets the change flag in the status register.
// - A new code counts as a change only after it persisted long enough.
// - Filter settings need one, three, five or seven matching codes in a row.
// - A rising edge of the rx reset bit resets the receive side.
// - Codes 02,04,06,08,20 hex mark stratum 1, unknown, 2, 3, user levels.
// - Codes 11,14,18 hex mark SONET minimum, stratum 4, do not use.
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ssmb_engine (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic SRST,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [ssmb_pkg::ADDR_W-1:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] HRDATA,
	// Transmit data link slot from the framer
	input wire logic TX_FDL_STROBE,
	output logic TX_FDL_DATA,
	output logic TX_FDL_VALID,
	// Receive data link slot from the framer
	input wire logic RX_FDL_STROBE,
	input wire logic RX_FDL_DATA,
	// Interrupt
	output logic IRQ
);
	localparam int MW = ssmb_pkg::MSG_W;
	localparam int WW = ssmb_pkg::WORD_W;

	logic [ssmb_pkg::CTRL_W-1:0] ctrl_r;
	logic [MW-1:0] tx_msg_r;
	logic [MW-1:0] rx_msg_r;
	logic [ssmb_pkg::STAT_W-1:0] stat_r;
	logic [ssmb_pkg::STAT_W-1:0] ien_r;
	logic wr_pend_r;
	logic [7:0] wr_idx_r;
	logic rxrst_d_r;
	logic [WW-1:0] tx_sh_r;
	logic [3:0] tx_idx_r;
	logic tx_act_r;
	logic [WW-1:0] rx_sh_r;
	logic [WW-1:0] rx_sh_nxt;
	logic [3:0] gap_r;
	logic locked_r;
	logic code_stb;
	logic err_stb;
	logic acc_stb;
	logic [MW-1:0] acc_code;
	logic chg_evt;
	logic rx_clr;
	logic addr_ok;
	logic req;
	logic [7:0] req_idx;
	logic [31:0] rd_mux;
	logic clr_wr;
	logic [WW-1:0] tx_word;

	wire send_en = ctrl_r[ssmb_pkg::CTRL_SEND];
	wire rx_en = ctrl_r[ssmb_pkg::CTRL_RXEN];
	wire [1:0] flt_sel = {ctrl_r[ssmb_pkg::CTRL_FLT_HI],
		ctrl_r[ssmb_pkg::CTRL_FLT_LO]};

	// Bus address phase
	assign req_idx = HADDR[9:2];
	assign addr_ok = HADDR[11:10] == 2'h0 && HADDR[1:0] == 2'h0;
	assign req = HSEL && HREADY && HTRANS == ssmb_pkg::HTRANS_NONSEQ;
	assign clr_wr = wr_pend_r && wr_idx_r == ssmb_pkg::IDX_ICLR;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			wr_pend_r <= 1'b0;
			wr_idx_r <= 8'h00;
		end else begin
			wr_pend_r <= req && HWRITE && addr_ok;
			wr_idx_r <= req_idx;
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// Clear reads as zero; unmapped reads too
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (addr_ok) begin
			case (req_idx)
				ssmb_pkg::IDX_CTRL: rd_mux[ssmb_pkg::CTRL_W-1:0] = ctrl_r;
				ssmb_pkg::IDX_TXMSG: rd_mux[MW-1:0] = tx_msg_r;
				ssmb_pkg::IDX_RXMSG: rd_mux[MW-1:0] = rx_msg_r;
				ssmb_pkg::IDX_STAT: rd_mux[ssmb_pkg::STAT_W-1:0] = stat_r;
				ssmb_pkg::IDX_IEN: rd_mux[ssmb_pkg::STAT_W-1:0] = ien_r;
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			HRDATA <= 32'h0000_0000;
		end else if (req && !HWRITE) begin
			HRDATA <= rd_mux;
		end
	end

	// Writable registers, applied in the data phase
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			ctrl_r <= ssmb_pkg::CTRL_RESET;
			tx_msg_r <= ssmb_pkg::TX_RESET;
			ien_r <= '0;
		end else if (wr_pend_r) begin
			case (wr_idx_r)
				ssmb_pkg::IDX_CTRL: ctrl_r <= HWDATA[ssmb_pkg::CTRL_W-1:0];
				ssmb_pkg::IDX_TXMSG: tx_msg_r <= HWDATA[MW-1:0];
				ssmb_pkg::IDX_IEN: ien_r <= HWDATA[ssmb_pkg::STAT_W-1:0];
				default: ;
			endcase
		end
	end

	// Transmit: lead zero, message, trail zero, abort byte
	assign tx_word = {1'b0, tx_msg_r, 1'b0, ssmb_pkg::ABORT_BYTE};

	// Stop only at a word boundary so no word is cut short
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			tx_sh_r <= '0;
			tx_idx_r <= 4'h0;
			tx_act_r <= 1'b0;
			TX_FDL_DATA <= 1'b1;
			TX_FDL_VALID <= 1'b0;
		end else if (TX_FDL_STROBE) begin
			if (tx_idx_r == 4'h0) begin
				if (send_en) begin
					tx_act_r <= 1'b1;
					TX_FDL_DATA <= tx_word[WW-1];
					TX_FDL_VALID <= 1'b1;
					tx_sh_r <= {tx_word[WW-2:0], 1'b0};
					tx_idx_r <= 4'h1;
				end else begin
					tx_act_r <= 1'b0;
					TX_FDL_DATA <= 1'b1;
					TX_FDL_VALID <= 1'b0;
				end
			end else begin
				TX_FDL_DATA <= tx_sh_r[WW-1];
				TX_FDL_VALID <= 1'b1;
				tx_sh_r <= {tx_sh_r[WW-2:0], 1'b0};
				tx_idx_r <= tx_idx_r + 4'h1;
			end
		end
	end

	// Receive reset on rising edge of the control bit
	assign rx_clr = ctrl_r[ssmb_pkg::CTRL_RXRST] && !rxrst_d_r;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			rxrst_d_r <= 1'b0;
		end else begin
			rxrst_d_r <= ctrl_r[ssmb_pkg::CTRL_RXRST];
		end
	end

	// Receive framing: word found by guard zeros and abort byte
	assign rx_sh_nxt = {rx_sh_r[WW-2:0], RX_FDL_DATA};
	wire frame_hit = !rx_sh_nxt[WW-1] && !rx_sh_nxt[8] &&
		rx_sh_nxt[7:0] == ssmb_pkg::ABORT_BYTE;
	wire rx_step = RX_FDL_STROBE && rx_en;
	assign code_stb = rx_step && frame_hit &&
		(!locked_r || gap_r == ssmb_pkg::LAST_BIT);
	assign err_stb = rx_step && locked_r && gap_r == ssmb_pkg::LAST_BIT &&
		!frame_hit;

	always_ff @(posedge CLOCK) begin
		if (SRST || rx_clr) begin
			rx_sh_r <= '0;
			gap_r <= 4'h0;
			locked_r <= 1'b0;
		end else if (rx_step) begin
			rx_sh_r <= rx_sh_nxt;
			if (code_stb) begin
				gap_r <= 4'h0;
				locked_r <= 1'b1;
			end else if (err_stb) begin
				locked_r <= 1'b0;
				gap_r <= 4'h0;
			end else begin
				gap_r <= gap_r + 4'h1;
			end
		end
	end

	ssmb_rx_filter #(
		.MSG_W(MW)
	) u_filter (
		.clk(CLOCK),
		.srst(SRST),
		.clr(rx_clr),
		.code_stb(code_stb),
		.code(rx_sh_nxt[14:9]),
		.err_stb(err_stb),
		.sel(flt_sel),
		.acc_stb(acc_stb),
		.acc_code(acc_code)
	);

	assign chg_evt = acc_stb && rx_en && acc_code != rx_msg_r;

	always_ff @(posedge CLOCK) begin
		if (SRST || rx_clr) begin
			rx_msg_r <= ssmb_pkg::RX_PRESET;
		end else if (chg_evt) begin
			rx_msg_r <= acc_code;
		end
	end

	// Sticky status: a set in the clear cycle wins
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			stat_r <= '0;
		end else begin
			stat_r[ssmb_pkg::STAT_CHG] <= chg_evt ||
				(stat_r[ssmb_pkg::STAT_CHG] &&
				!(clr_wr && HWDATA[ssmb_pkg::STAT_CHG]));
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(stat_r & ien_r);
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SRST);

	a_tx_start_zero: assert property (TX_FDL_STROBE && send_en &&
		tx_idx_r == 4'h0 |=> TX_FDL_VALID && !TX_FDL_DATA)
		else $error("code word did not start with zero");
	a_tx_abort_ones: assert property (TX_FDL_STROBE && tx_act_r &&
		tx_idx_r[3] |=> TX_FDL_DATA && TX_FDL_VALID)
		else $error("abort byte bit not one");
	a_tx_trail_zero: assert property (TX_FDL_STROBE && tx_idx_r == 4'h7
		|=> !TX_FDL_DATA)
		else $error("trailing guard bit not zero");
	a_tx_stop_idle: assert property (TX_FDL_STROBE && !send_en &&
		tx_idx_r == 4'h0 |=> !TX_FDL_VALID && TX_FDL_DATA)
		else $error("code sent with send bit clear");
	a_rx_disabled: assert property (!rx_en |-> !code_stb && !chg_evt)
		else $error("detection while receive disabled");
	a_rx_preset: assert property ($rose(ctrl_r[ssmb_pkg::CTRL_RXRST])
		|=> rx_msg_r == ssmb_pkg::RX_PRESET)
		else $error("rx message not preset after reset edge");
	a_rx_update: assert property (chg_evt |=> rx_msg_r == $past(acc_code) &&
		stat_r[ssmb_pkg::STAT_CHG])
		else $error("change not reported");
	a_flag_sticky: assert property (stat_r[ssmb_pkg::STAT_CHG] && !clr_wr
		|=> stat_r[ssmb_pkg::STAT_CHG])
		else $error("change flag dropped without clear");
	a_irq_level: assert property (##1 IRQ == $past(|(stat_r & ien_r)))
		else $error("interrupt does not follow enabled status");
	a_rx_hold: assert property (!chg_evt && !rx_clr |=> $stable(rx_msg_r))
		else $error("rx message changed without event");

	c_tx_word: cover property (TX_FDL_STROBE && tx_idx_r == ssmb_pkg::LAST_BIT);
	c_change: cover property (chg_evt ##[1:20] IRQ);
	c_quality: cover property (chg_evt && (acc_code == ssmb_pkg::QL_STRATUM1 ||
		acc_code == ssmb_pkg::QL_DO_NOT_USE));
	c_rx_reset: cover property (rx_clr && stat_r[ssmb_pkg::STAT_CHG]);
endmodule
`default_nettype wire

// file: sim/ssmb_link_partner.sv
// Far-end link model: slot strobes, code word sender, tx bit capture
`timescale 1ns/1ps
`default_nettype none
module ssmb_link_partner (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Our transmitter as seen from the far end
	input wire logic tx_data,
	input wire logic tx_valid,
	output logic tx_stb,
	output logic [15:0] tx_word,
	output logic [15:0] tx_cnt,
	// Far-end code words toward our receiver
	input wire logic rx_on,
	input wire logic [5:0] rx_msg,
	output logic rx_stb,
	output logic rx_data,
	output logic [7:0] rx_words
);
	logic [1:0] div_r;
	logic [3:0] pos_r;
	logic bit_r;
	logic [15:0] word;
	// Same word repeated back to back, so any persistence filter setting is met
	assign word = {1'b0, rx_msg, 1'b0, ssmb_pkg::ABORT_BYTE};
	assign tx_stb = (div_r == 2'h0);
	assign rx_stb = (div_r == 2'h2);
	// Bit valid only in its slot; stale value shows inverted
	assign rx_data = rx_stb ? bit_r : ~bit_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			div_r <= 2'h0;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (srst || !rx_on) begin
			pos_r <= 4'h0;
			rx_words <= 8'h00;
		end else if (div_r == 2'h1) begin
			pos_r <= pos_r + 4'h1;
			if (pos_r == 4'hF) begin
				rx_words <= rx_words + 8'h01;
			end
		end
	end
	// Idle toggling can never fake the eight-ones tail
	always_ff @(posedge clk) begin
		if (srst) begin
			bit_r <= 1'b1;
		end else if (div_r == 2'h1) begin
			bit_r <= rx_on ? word[4'hF - pos_r] : ~bit_r;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_word <= 16'h0000;
			tx_cnt <= 16'h0000;
		end else if (tx_stb && tx_valid) begin
			tx_word <= {tx_word[14:0], tx_data};
			tx_cnt <= tx_cnt + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// file: sim/ssmb_engine_bench.sv
// Self-checking bench for the status message code engine
`timescale 1ns/1ps
`default_nettype none
module ssmb_engine_bench;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready, hresp, tx_stb, tx_data, tx_valid, rx_stb, rx_data, irq;
	logic [31:0] hrdata, rv;
	logic [15:0] tx_word, tx_cnt;
	logic [7:0] rx_words;
	logic rx_on = 1'b0;
	logic [5:0] rx_msg = 6'h00;
	logic [5:0] codes [8];
	logic [2:0] need [4];
	int err_total = 0;
	int tests_run = 0;
	always #12.5 clock = ~clock;
	ssmb_engine i_ssmb_engine (
		.CLOCK(clock), .SRST(srst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hready), .HREADYOUT(hready), .HRESP(hresp),
		.HRDATA(hrdata), .TX_FDL_STROBE(tx_stb), .TX_FDL_DATA(tx_data),
		.TX_FDL_VALID(tx_valid), .RX_FDL_STROBE(rx_stb),
		.RX_FDL_DATA(rx_data), .IRQ(irq)
	);
	ssmb_link_partner i_ssmb_link_partner (
		.clk(clock), .srst(srst), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_stb(tx_stb), .tx_word(tx_word), .tx_cnt(tx_cnt),
		.rx_on(rx_on), .rx_msg(rx_msg), .rx_stb(rx_stb),
		.rx_data(rx_data), .rx_words(rx_words)
	);
	task automatic print_verdict();
		if (err_total == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s exp %h got %h", name, exp, got);
		end
	endtask
	task automatic hold_ready();
		int n;
		n = 0;
		@(posedge clock);
		while (hready !== 1'b1) begin
			n++;
			if (n > 50) begin
				chk("hready", 32'h1, 32'h0);
				print_verdict();
			end
			@(posedge clock);
		end
	endtask
	// Trailing idle cycle avoids the write-then-read hazard
	task automatic bus(input logic wr, input logic [7:0] idx,
		input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= ssmb_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= {2'h0, idx, 2'h0};
		hold_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		hold_ready();
		rv = hrdata;
		@(posedge clock);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		chk($sformatf("reg %h", idx), exp, rv);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic wait_ev(input logic kind, input logic [15:0] n);
		int i;
		for (i = 0; i < 2000; i++) begin
			@(posedge clock);
			if (kind ? (tx_cnt == n) : (irq === 1'b1)) begin
				return;
			end
		end
		chk("wait", 32'h1, 32'h0);
		print_verdict();
	endtask
	initial begin
		int i;
		logic [1:0] f;
		codes = '{ssmb_pkg::QL_STRATUM1, ssmb_pkg::QL_UNKNOWN,
			ssmb_pkg::QL_STRATUM2, ssmb_pkg::QL_STRATUM3, ssmb_pkg::QL_USER,
			ssmb_pkg::QL_SONET_MIN, ssmb_pkg::QL_STRATUM4,
			ssmb_pkg::QL_DO_NOT_USE};
		need = '{ssmb_pkg::FLT_NONE, ssmb_pkg::FLT_THREE,
			ssmb_pkg::FLT_FIVE, ssmb_pkg::FLT_SEVEN};
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		rdc(ssmb_pkg::IDX_CTRL, 32'h0);
		rdc(ssmb_pkg::IDX_RXMSG, 32'h3F);
		rdc(ssmb_pkg::IDX_TXMSG, 32'h0);
		rdc(ssmb_pkg::IDX_IEN, 32'h0);
		rdc(ssmb_pkg::IDX_ICLR, 32'h0);
		rdc(8'h01, 32'h0);
		rx_msg <= ssmb_pkg::QL_STRATUM1;
		rx_on <= 1'b1;
		repeat (300) @(posedge clock);
		rdc(ssmb_pkg::IDX_STAT, 32'h0);
		rdc(ssmb_pkg::IDX_RXMSG, 32'h3F);
		bus(1'b1, ssmb_pkg::IDX_IEN, 32'h1);
		bus(1'b1, ssmb_pkg::IDX_TXMSG, {26'h0, ssmb_pkg::QL_SONET_MIN});
		bus(1'b1, ssmb_pkg::IDX_CTRL, 32'h1);
		wait_ev(1'b1, 16'h0010);
		chk("tx word", {17'h0, ssmb_pkg::QL_SONET_MIN, 9'h0FF}, {16'h0, tx_word});
		wait_ev(1'b1, 16'h0020);
		chk("tx word", {17'h0, ssmb_pkg::QL_SONET_MIN, 9'h0FF}, {16'h0, tx_word});
		bus(1'b1, ssmb_pkg::IDX_CTRL, 32'h0);
		repeat (150) @(posedge clock);
		chk("tx bits", 32'h0, {28'h0, tx_cnt[3:0]});
		chk("tx idle", 32'h1, {30'h0, tx_valid, tx_data});
		for (i = 0; i < 8; i++) begin
			f = 2'(i % 4);
			rx_on <= 1'b0;
			bus(1'b1, ssmb_pkg::IDX_CTRL, {27'h0, 2'h2, f, 1'b0});
			bus(1'b1, ssmb_pkg::IDX_CTRL, {27'h0, 2'h3, f, 1'b0});
			bus(1'b1, ssmb_pkg::IDX_ICLR, 32'h1);
			rdc(ssmb_pkg::IDX_RXMSG, 32'h3F);
			rdc(ssmb_pkg::IDX_STAT, 32'h0);
			rx_msg <= codes[i];
			rx_on <= 1'b1;
			wait_ev(1'b0, 16'h0);
			chk("words", {29'h0, need[f]}, {24'h0, rx_words});
			rdc(ssmb_pkg::IDX_RXMSG, {26'h0, codes[i]});
			rdc(ssmb_pkg::IDX_STAT, 32'h1);
			bus(1'b1, ssmb_pkg::IDX_IEN, 32'h0);
			@(posedge clock);
			chk("irq masked", 32'h0, {31'h0, irq});
			bus(1'b1, ssmb_pkg::IDX_IEN, 32'h1);
			@(posedge clock);
			chk("irq", 32'h1, {31'h0, irq});
			bus(1'b1, ssmb_pkg::IDX_ICLR, 32'h1);
			repeat (150) @(posedge clock);
			rdc(ssmb_pkg::IDX_STAT, 32'h0);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
